/* rtl/tap_device.sv */
`default_nettype none
module tap_device
    import tap_pkg::*;
(
    tap_if.device link,
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic test_port_enable_fuse_i,
    input wire logic test_port_disable_bit_i,
    input wire logic [tap_pkg::BSCAN_WIDTH-1:0] bscan_pins_i,
    input wire logic [tap_pkg::PROG_WIDTH-1:0] prog_status_i,
    input wire logic [tap_pkg::DEBUG_WIDTH-1:0] debug_status_i,
    output logic port_active_o,
    output logic pullup_en_o,
    output logic ext_reset_seen_o,
    output logic [3:0] instr_o,
    output logic [tap_pkg::BSCAN_WIDTH-1:0] bscan_update_o,
    output logic [tap_pkg::PROG_WIDTH-1:0] prog_update_o,
    output logic [tap_pkg::DEBUG_WIDTH-1:0] debug_update_o
);
    import tap_pkg::*;

    // ****************************************
    // port enable, system clock side
    // ****************************************
    logic enable_reg;
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            enable_reg <= 1'b0;
        end else if (clk_en_i) begin
            enable_reg <= test_port_enable_fuse_i && !test_port_disable_bit_i;
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= 1'b1;
            ext_reset_seen_o <= 1'b0;
            port_active_o <= 1'b0;
            pullup_en_o <= 1'b0;
        end else if (clk_en_i) begin
            rst_meta_reg <= link.rst_n_in;
            rst_sync_reg <= rst_meta_reg;
            ext_reset_seen_o <= !rst_sync_reg;
            port_active_o <= enable_reg;
            pullup_en_o <= enable_reg;
        end
    end

    // ****************************************
    // enable into the tck domain
    // ****************************************
    logic en_meta_reg;
    logic en_tck_reg;
    always_ff @(posedge link.tck) begin
        en_meta_reg <= enable_reg;
        en_tck_reg <= en_meta_reg;
    end
    // reset held while port disabled; no trst pin exists
    wire logic tap_hold = !en_tck_reg;

    // ****************************************
    // controller
    // ****************************************
    tap_state_e state_reg;
    tap_state_e state_next;
    always_comb begin
        unique case (state_reg)
            ST_RESET: state_next = link.tms ? ST_RESET : ST_IDLE;
            ST_IDLE: state_next = link.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_next = link.tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_next = link.tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_next = link.tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_next = link.tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: state_next = link.tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: state_next = link.tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_next = link.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_next = link.tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_next = link.tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_next = link.tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_next = link.tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: state_next = link.tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: state_next = link.tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_next = link.tms ? ST_SEL_DR : ST_IDLE;
            default: state_next = ST_RESET;
        endcase
    end
    always_ff @(posedge link.tck) begin
        if (tap_hold) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // instruction register
    // ****************************************
    logic [3:0] ir_shift_reg;
    logic [3:0] ir_reg;
    always_ff @(posedge link.tck) begin
        if (state_reg == ST_CAP_IR) begin
            ir_shift_reg <= IR_CAPTURE_VALUE;
        end else if (state_reg == ST_SH_IR) begin
            ir_shift_reg <= {link.tdi, ir_shift_reg[3:1]};
        end
    end
    always_ff @(posedge link.tck) begin
        if (tap_hold || state_reg == ST_RESET) begin
            ir_reg <= IR_RESET_VALUE;
        end else if (state_reg == ST_UPD_IR) begin
            ir_reg <= ir_shift_reg;
        end
    end

    // ****************************************
    // data chains
    // ****************************************
    logic bypass_reg;
    logic [31:0] id_reg;
    logic [BSCAN_WIDTH-1:0] bscan_reg;
    logic [PROG_WIDTH-1:0] prog_reg;
    logic [DEBUG_WIDTH-1:0] debug_reg;
    wire logic cap_dr = state_reg == ST_CAP_DR;
    wire logic sh_dr = state_reg == ST_SH_DR;
    wire logic sel_bscan = ir_reg == INSTR_EXTEST || ir_reg == INSTR_SAMPLE;
    always_ff @(posedge link.tck) begin
        if (cap_dr) begin
            bypass_reg <= 1'b0;
            id_reg <= ID_WORD;
            bscan_reg <= bscan_pins_i;
            prog_reg <= prog_status_i;
            debug_reg <= debug_status_i;
        end else if (sh_dr) begin
            unique case (1'b1)
                ir_reg == INSTR_IDCODE: id_reg <= {link.tdi, id_reg[31:1]};
                sel_bscan: bscan_reg <= {link.tdi, bscan_reg[BSCAN_WIDTH-1:1]};
                ir_reg == INSTR_PROG: prog_reg <= {link.tdi, prog_reg[PROG_WIDTH-1:1]};
                ir_reg == INSTR_DEBUG: debug_reg <= {link.tdi, debug_reg[DEBUG_WIDTH-1:1]};
                default: bypass_reg <= link.tdi;
            endcase
        end
    end
    always_ff @(posedge link.tck) begin
        if (tap_hold || state_reg == ST_RESET) begin
            bscan_update_o <= '0;
            prog_update_o <= '0;
            debug_update_o <= '0;
            instr_o <= IR_RESET_VALUE;
        end else begin
            instr_o <= ir_reg;
            if (state_reg == ST_UPD_DR) begin
                if (sel_bscan) bscan_update_o <= bscan_reg;
                if (ir_reg == INSTR_PROG) prog_update_o <= prog_reg;
                if (ir_reg == INSTR_DEBUG) debug_update_o <= debug_reg;
            end
        end
    end

    // ****************************************
    // serial output on falling tck
    // ****************************************
    logic tdo_mux;
    always_comb begin
        if (state_reg == ST_SH_IR) tdo_mux = ir_shift_reg[0];
        else if (ir_reg == INSTR_IDCODE) tdo_mux = id_reg[0];
        else if (sel_bscan) tdo_mux = bscan_reg[0];
        else if (ir_reg == INSTR_PROG) tdo_mux = prog_reg[0];
        else if (ir_reg == INSTR_DEBUG) tdo_mux = debug_reg[0];
        else tdo_mux = bypass_reg;
    end
    always_ff @(negedge link.tck) begin
        if (tap_hold) begin
            link.tdo <= 1'b0;
            link.tdo_oe <= 1'b0;
        end else begin
            link.tdo <= tdo_mux;
            link.tdo_oe <= state_reg == ST_SH_IR || state_reg == ST_SH_DR;
        end
    end
endmodule // tap_device
`default_nettype wire

/* rtl/tap_host.sv */
`default_nettype none
module tap_host
    import tap_pkg::*;
(
    tap_if.host link,
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic req_valid_i,
    input wire logic req_is_dr_i,
    input wire logic [5:0] req_len_i,
    input wire logic [31:0] req_data_i,
    input wire logic req_reset_i,
    input wire logic sys_reset_i,
    output logic req_ready_o,
    output logic done_o,
    output logic [31:0] resp_data_o,
    output logic ext_reset_seen_o
);
    import tap_pkg::*;

    // tck made here by a divider; host shifts tms/tdi on tck low phase
    typedef enum logic [4:0] {
        H_IDLE = 5'h01, H_NAV = 5'h02, H_SHIFT = 5'h04, H_EXIT = 5'h08, H_DONE = 5'h10
    } host_state_e;
    host_state_e st_reg;
    logic [7:0] div_reg;
    logic [9:0] tms_seq_reg;
    logic [3:0] seq_cnt_reg;
    logic [5:0] bit_cnt_reg;
    logic [31:0] out_reg;
    logic [31:0] in_reg;
    logic [5:0] len_reg;
    logic tdo_meta_reg;
    logic tdo_sync_reg;
    logic rin_meta_reg;
    logic rin_sync_reg;
    wire logic fall = link.tck && div_reg == 8'(TCK_DIV - 1);
    wire logic rise = !link.tck && div_reg == 8'(TCK_DIV - 1);

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            tdo_meta_reg <= 1'b1;
            tdo_sync_reg <= 1'b1;
            rin_meta_reg <= 1'b1;
            rin_sync_reg <= 1'b1;
        end else if (clk_en_i) begin
            tdo_meta_reg <= link.tdo;
            tdo_sync_reg <= tdo_meta_reg;
            rin_meta_reg <= link.rst_n_in;
            rin_sync_reg <= rin_meta_reg;
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            link.rst_n_out <= 1'b0;
            link.rst_n_oe <= 1'b0;
            ext_reset_seen_o <= 1'b0;
        end else if (clk_en_i) begin
            link.rst_n_oe <= sys_reset_i;
            ext_reset_seen_o <= !rin_sync_reg;
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            div_reg <= '0;
            link.tck <= 1'b0;
        end else if (clk_en_i) begin
            if (div_reg == 8'(TCK_DIV - 1)) begin
                div_reg <= '0;
                link.tck <= !link.tck;
            end else begin
                div_reg <= div_reg + 8'h01;
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            st_reg <= H_IDLE;
            link.tms <= 1'b1;
            link.tdi <= 1'b1;
            req_ready_o <= 1'b0;
            done_o <= 1'b0;
            resp_data_o <= '0;
            tms_seq_reg <= '0;
            seq_cnt_reg <= '0;
            bit_cnt_reg <= '0;
            out_reg <= '0;
            in_reg <= '0;
            len_reg <= '0;
        end else if (clk_en_i) begin
            done_o <= 1'b0;
            req_ready_o <= st_reg == H_IDLE && !req_valid_i;
            unique case (st_reg)
                H_IDLE: if (req_valid_i && req_ready_o) begin
                    if (req_reset_i) begin
                        tms_seq_reg <= 10'h01f; // five highs then idle
                        seq_cnt_reg <= 4'h6;
                    end else if (req_is_dr_i) begin
                        tms_seq_reg <= 10'h001; // 1,0,0 lsb first
                        seq_cnt_reg <= 4'h3;
                    end else begin
                        tms_seq_reg <= 10'h003; // 1,1,0,0
                        seq_cnt_reg <= 4'h4;
                    end
                    len_reg <= req_reset_i ? 6'h00 : req_len_i;
                    out_reg <= req_data_i;
                    in_reg <= '0;
                    st_reg <= H_NAV;
                end
                H_NAV: if (fall) begin
                    if (seq_cnt_reg == 4'h0) begin
                        st_reg <= len_reg == 6'h00 ? H_DONE : H_SHIFT;
                        bit_cnt_reg <= len_reg;
                        if (len_reg != 6'h00) begin
                            // first bit must stand before the first shift-state rise
                            link.tdi <= out_reg[0];
                            out_reg <= {1'b0, out_reg[31:1]};
                            link.tms <= len_reg == 6'h01;
                        end
                    end else begin
                        link.tms <= tms_seq_reg[0];
                        tms_seq_reg <= {1'b0, tms_seq_reg[9:1]};
                        seq_cnt_reg <= seq_cnt_reg - 4'h1;
                    end
                end
                H_SHIFT: begin
                    if (fall) begin
                        // sync lags two clocks: take the bit set one tck period ago
                        in_reg <= {tdo_sync_reg, in_reg[31:1]};
                        link.tdi <= out_reg[0];
                        out_reg <= {1'b0, out_reg[31:1]};
                        link.tms <= bit_cnt_reg == 6'h01;
                    end else if (rise) begin
                        bit_cnt_reg <= bit_cnt_reg - 6'h01;
                        if (bit_cnt_reg == 6'h01) begin
                            tms_seq_reg <= 10'h001; // 1,0 after exit1
                            seq_cnt_reg <= 4'h2;
                            st_reg <= H_EXIT;
                        end
                    end
                end
                H_EXIT: if (fall) begin
                    if (seq_cnt_reg == 4'h2) begin
                        // last chain bit, driven before the exit rise
                        in_reg <= {tdo_sync_reg, in_reg[31:1]};
                    end
                    if (seq_cnt_reg == 4'h0) begin
                        st_reg <= H_DONE;
                    end else begin
                        link.tms <= tms_seq_reg[0] | (seq_cnt_reg == 4'h2);
                        tms_seq_reg <= {1'b0, tms_seq_reg[9:1]};
                        seq_cnt_reg <= seq_cnt_reg - 4'h1;
                    end
                end
                H_DONE: begin
                    resp_data_o <= in_reg >> (6'd32 - len_reg);
                    done_o <= 1'b1;
                    st_reg <= H_IDLE;
                end
                default: st_reg <= H_IDLE;
            endcase
        end
    end
endmodule // tap_host
`default_nettype wire

/* rtl/tap_if.sv */
`default_nettype none
interface tap_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic rst_n_out;
    logic rst_n_oe;
    logic rst_n_in;
    modport device (input tck, input tms, input tdi, output tdo, output tdo_oe,
        input rst_n_in);
    modport host (output tck, output tms, output tdi, input tdo, input tdo_oe,
        output rst_n_out, output rst_n_oe, input rst_n_in);
endinterface
`default_nettype wire

/* rtl/tap_pkg.sv */
`default_nettype none
package tap_pkg;
    localparam int IR_WIDTH = 4;
    localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;
    // instruction codes; the values of all but bypass are arbitrary
    localparam logic [3:0] INSTR_EXTEST = 4'h0;
    localparam logic [3:0] INSTR_IDCODE = 4'h1;
    localparam logic [3:0] INSTR_SAMPLE = 4'h2;
    localparam logic [3:0] INSTR_PROG = 4'h4;
    localparam logic [3:0] INSTR_DEBUG = 4'h8;
    localparam logic [3:0] INSTR_BYPASS = 4'hf;
    localparam logic [3:0] IR_RESET_VALUE = INSTR_IDCODE;
    // identification word: arbitrary value
    localparam logic [31:0] ID_WORD = 32'h1234_5679;
    localparam int BSCAN_WIDTH = 8;
    localparam int PROG_WIDTH = 16;
    localparam int DEBUG_WIDTH = 8;
    localparam int TMS_RESET_COUNT = 5;
    localparam int TCK_DIV = 2;
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PAU_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PAU_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } tap_state_e;
endpackage
`default_nettype wire

/* tb/tap_chk.sv */
`default_nettype none
module tap_chk (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdo,
    input wire logic tdo_oe
);
    import tap_pkg::*;
    // ************************
    // reference state walk
    // ************************
    tap_state_e st_reg;
    tap_state_e st_next;
    logic shifting;
    always_comb begin
        case (st_reg)
            ST_RESET: st_next = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: st_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: st_next = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: st_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: st_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: st_next = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: st_next = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: st_next = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: st_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: st_next = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: st_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: st_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: st_next = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: st_next = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: st_next = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: st_next = tms ? ST_SEL_DR : ST_IDLE;
            default: st_next = ST_RESET;
        endcase
    end
    // async clear: tck stands still while reset is held
    always_ff @(posedge tck or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end
    assign shifting = (st_reg == ST_SH_DR) || (st_reg == ST_SH_IR);
    // ************************
    // assertions
    // ************************
    chk_oe_only_shift:
    assert property (@(posedge tck) disable iff (!rstn_i) tdo_oe |-> shifting)
        else $error("tdo driven outside a shift state");
    chk_oe_while_shift:
    assert property (@(posedge tck) disable iff (!rstn_i) shifting |-> tdo_oe)
        else $error("tdo not driven while shifting");
    chk_tdo_on_fall:
    assert property (@(posedge clock_i) disable iff (!rstn_i)
        ($changed(tdo) || $changed(tdo_oe)) |-> !tck)
        else $error("tdo moved while tck high");
    chk_ir_capture_val:
    assert property (@(posedge tck) disable iff (!rstn_i) (st_reg == ST_CAP_IR) |=>
        (tdo_oe && tdo) ##1 (tdo_oe && !tdo) [*3])
        else $error("captured instruction value wrong");
    chk_ir_entry_tms:
    assert property (@(posedge tck) disable iff (!rstn_i)
        (st_reg == ST_SEL_IR && !tms) |=> !tms)
        else $error("shift-ir not entered after capture");
    chk_ir_len_tms:
    assert property (@(posedge tck) disable iff (!rstn_i)
        (st_reg == ST_CAP_IR) |=> !tms [*3] ##1 tms)
        else $error("instruction shift length wrong");
    chk_exit_update_idle:
    assert property (@(posedge tck) disable iff (!rstn_i)
        (st_reg == ST_EX1_IR || st_reg == ST_EX1_DR) |-> tms ##1 !tms)
        else $error("exit not followed by update and idle");
    chk_dr_entry_tms:
    assert property (@(posedge tck) disable iff (!rstn_i)
        (st_reg == ST_SEL_DR && !tms) |=> !tms)
        else $error("shift-dr not entered after capture");
    chk_five_high_reset:
    assert property (@(posedge tck) disable iff (!rstn_i) tms [*5] |=> !tdo_oe)
        else $error("tdo driven after five tms-high clocks");
    cover property (@(posedge tck) disable iff (!rstn_i) st_reg == ST_UPD_IR);
    cover property (@(posedge tck) disable iff (!rstn_i) st_reg == ST_UPD_DR);
    cover property (@(posedge tck) disable iff (!rstn_i) tms [*5]);
endmodule // tap_chk
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tap_pkg::*;
    localparam int TIMEOUT_CYCLES = 20000;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic test_port_enable_fuse = 1'b1;
    logic test_port_disable_bit = 1'b0;
    logic [BSCAN_WIDTH-1:0] bscan_pins = 8'h3c;
    logic [PROG_WIDTH-1:0] prog_status = 16'hc35a;
    logic [DEBUG_WIDTH-1:0] debug_status = 8'h69;
    logic req_valid = 1'b0;
    logic req_is_dr = 1'b0;
    logic req_reset = 1'b0;
    logic sys_reset = 1'b0;
    logic [5:0] req_len = 6'h0;
    logic [31:0] req_data = 32'h0;
    logic req_ready, done, dev_seen, host_seen, port_active, pullup_en;
    logic [3:0] instr;
    logic [BSCAN_WIDTH-1:0] bscan_update;
    logic [PROG_WIDTH-1:0] prog_update;
    logic [DEBUG_WIDTH-1:0] debug_update;
    logic [31:0] resp_data, got;
    logic [3:0] ops [4] = '{INSTR_SAMPLE, INSTR_EXTEST, INSTR_PROG, INSTR_DEBUG};
    logic [5:0] lens [4] = '{6'h8, 6'h8, 6'h10, 6'h8};
    logic [31:0] caps [4] = '{32'h3c, 32'h3c, 32'hc35a, 32'h69};
    logic [31:0] dat [4] = '{32'h11, 32'h96, 32'hbeef, 32'h5e};
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    always #12.5 clock_i = ~clock_i;
    tap_if link();
    // open-drain reset line with pull-up
    assign link.rst_n_in = link.rst_n_oe ? link.rst_n_out : 1'b1;
    tap_device tap_device_inst (.link(link), .clock_i(clock_i), .rstn_i(rstn_i),
        .clk_en_i(1'b1), .test_port_enable_fuse_i(test_port_enable_fuse),
        .test_port_disable_bit_i(test_port_disable_bit), .bscan_pins_i(bscan_pins),
        .prog_status_i(prog_status), .debug_status_i(debug_status),
        .port_active_o(port_active), .pullup_en_o(pullup_en),
        .ext_reset_seen_o(dev_seen), .instr_o(instr), .bscan_update_o(bscan_update),
        .prog_update_o(prog_update), .debug_update_o(debug_update));
    tap_host tap_host_inst (.link(link), .clock_i(clock_i), .rstn_i(rstn_i),
        .clk_en_i(1'b1), .req_valid_i(req_valid), .req_is_dr_i(req_is_dr),
        .req_len_i(req_len), .req_data_i(req_data), .req_reset_i(req_reset),
        .sys_reset_i(sys_reset), .req_ready_o(req_ready), .done_o(done),
        .resp_data_o(resp_data), .ext_reset_seen_o(host_seen));
    tap_chk tap_chk_inst (.clock_i(clock_i), .rstn_i(rstn_i), .tck(link.tck),
        .tms(link.tms), .tdo(link.tdo), .tdo_oe(link.tdo_oe));
    // ************************
    // tasks
    // ************************
    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        comparisons++;
        if (seen !== expected) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one host transfer; called and returning at a falling clock edge
    task automatic scan(input logic rst, input logic dr, input logic [5:0] len,
            input logic [31:0] data);
        int n;
        n = 0;
        while (req_ready !== 1'b1) @(negedge clock_i);
        req_valid = 1'b1;
        req_reset = rst;
        req_is_dr = dr;
        req_len = len;
        req_data = data;
        @(negedge clock_i);
        req_valid = 1'b0;
        while (done !== 1'b1 && n < 4000) begin
            @(negedge clock_i);
            n++;
        end
        check(done, 1'b1);
        got = resp_data;
        // tck-domain outputs settle a tck period after update
        repeat (8) @(negedge clock_i);
    endtask
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYCLES) begin
            miscompares++;
            print_verdict();
        end
    end
    // ************************
    // main sequence
    // ************************
    initial begin
        repeat (16) @(negedge clock_i);
        rstn_i = 1'b1;
        repeat (4) @(negedge clock_i);
        check(port_active, 1'b1);
        check(pullup_en, 1'b1);
        scan(1'b1, 1'b0, 6'h0, 32'h0);
        check(instr, IR_RESET_VALUE);
        scan(1'b0, 1'b0, 6'h4, 32'(INSTR_IDCODE));
        check(got[3:0], IR_CAPTURE_VALUE);
        check(instr, INSTR_IDCODE);
        scan(1'b0, 1'b1, 6'h20, 32'h0);
        check(got, ID_WORD);
        for (int i = 0; i < 4; i++) begin
            scan(1'b0, 1'b0, 6'h4, 32'(ops[i]));
            check(instr, ops[i]);
            scan(1'b0, 1'b1, lens[i], dat[i]);
            check(got & ((32'h1 << lens[i]) - 32'h1), caps[i]);
        end
        scan(1'b0, 1'b0, 6'h4, 32'(INSTR_BYPASS));
        check(instr, INSTR_BYPASS);
        scan(1'b0, 1'b1, 6'h8, 32'ha5);
        check(got[7:0], 8'h4a);
        check(bscan_update, dat[1][7:0]);
        check(prog_update, dat[2][15:0]);
        check(debug_update, dat[3][7:0]);
        for (int i = 0; i < 2; i++) begin
            test_port_enable_fuse = 1'b1;
            test_port_disable_bit = 1'b0;
            scan(1'b1, 1'b0, 6'h0, 32'h0);
            scan(1'b0, 1'b0, 6'h4, 32'(INSTR_BYPASS));
            test_port_enable_fuse = i[0];
            test_port_disable_bit = i[0];
            // tck must run for the hold to reach the controller
            scan(1'b1, 1'b0, 6'h0, 32'h0);
            check(port_active, 1'b0);
            check(pullup_en, 1'b0);
            check(instr, IR_RESET_VALUE);
        end
        test_port_enable_fuse = 1'b1;
        test_port_disable_bit = 1'b0;
        scan(1'b1, 1'b0, 6'h0, 32'h0);
        scan(1'b0, 1'b0, 6'h4, 32'(INSTR_IDCODE));
        check(got[3:0], IR_CAPTURE_VALUE);
        sys_reset = 1'b1;
        repeat (8) @(negedge clock_i);
        check(dev_seen, 1'b1);
        check(host_seen, 1'b1);
        sys_reset = 1'b0;
        repeat (8) @(negedge clock_i);
        check(dev_seen, 1'b0);
        check(host_seen, 1'b0);
        print_verdict();
    end
endmodule // tb
`default_nettype wire
